/* logic/dma_addr_count_pkg.sv */
// Purpose: shared constants for the four-channel dma address/count block
// Assumes: one 50 MHz clock, registers reached by channel and register select
// Notes: register selects and the address split are local choices
package dma_addr_count_pkg;

   // ==========================================================
   // geometry
   localparam int NUM_CHAN = 4;
   localparam int CHAN_W = 2;
   localparam int SEL_W = 2;
   localparam int ADDR_W = CHAN_W + SEL_W;
   localparam int DATA_W = 32;
   localparam int LOCAL_W = 29;
   localparam int COUNT_W = 26;
   localparam int REMAIN_W = 27;
   localparam int CTRL_W = 11;

   // ==========================================================
   // register selects inside one channel (addr = {chan, sel})
   localparam logic [SEL_W-1:0] SEL_PCI_START = 2'h0;
   localparam logic [SEL_W-1:0] SEL_LOCAL_START = 2'h1;
   localparam logic [SEL_W-1:0] SEL_BYTE_COUNT = 2'h2;
   localparam logic [SEL_W-1:0] SEL_CONTROL = 2'h3;

   // ==========================================================
   // control word and address bit positions
   localparam int START_BIT = 0;
   localparam int FORCE_STOP_BIT = 1;
   localparam int DIR_BIT = 2;
   localparam int PCI_SPACE_SELECT_BIT = 3;
   localparam int LOCAL_ADDRESS_HOLD_BIT = 5;
   localparam int TERM_STATUS_BIT = 6;
   localparam int TERM_IRQ_ENABLE_BIT = 7;
   localparam int END_STATUS_BIT = 8;
   localparam int ALIGN_LO_BIT = 9;
   localparam int ALIGN_HI_BIT = 10;
   localparam int AREA_LO_BIT = 26;
   localparam int AREA_HI_BIT = 28;
   localparam int LW_LO_BITS = 2;
   localparam int HOLD_LO_BITS = 5;

   // ==========================================================
   // reset values, count limit and steps
   localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
   localparam logic [REMAIN_W-1:0] REMAIN_MAX = 27'h400_0000;
   localparam logic [REMAIN_W-1:0] LW_STEP = 27'h000_0004;
   localparam logic [DATA_W-1:0] ADDR_STEP = 32'h0000_0004;

endpackage

/* logic/reg_access_port.sv */
// Purpose: one register access port (internal peripheral bus or pci side)
// Assumes: requester holds req_i and its fields stable until ack_o
// Notes: read data is sampled on the taking edge, so it is the pre-write value
`timescale 1ns/100ps
module reg_access_port
   import dma_addr_count_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // requester side
   input wire logic req_i,
   input wire logic [DATA_W-1:0] rd_value_i,
   // arbitration
   input wire logic grant_i,
   output logic take_o,
   // answer
   output logic ack_o,
   output logic [DATA_W-1:0] rdata_o
);

   logic next_ack;
   logic [DATA_W-1:0] next_rdata;

   // ==========================================================
   // take a request once per hold; ack blocks a second take of the same one
   assign take_o = req_i && grant_i && !ack_o;

   always_comb
   begin
      next_ack = take_o;
      next_rdata = rdata_o;
      if (take_o)
      begin
         next_rdata = rd_value_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ack_o <= 1'b0;
         rdata_o <= RESET_WORD;
      end
      else
      begin
         ack_o <= next_ack;
         rdata_o <= next_rdata;
      end
   end

endmodule // reg_access_port

/* logic/pci_dma_address_count.sv */
// Purpose: per-channel start addresses, byte counts and control of a pci dma engine
// Assumes: mover answers each offered longword with xfer_ready_i or xfer_error_i
// Notes: both register ports see the same registers; peripheral port wins a tie
// Function
// R1: four channels, each with full register set
// R2: pci start address low two bits ignored
// R3: local start uses bits 28..0, longword aligned
// R4: local bits 28..26 select the bus area
// R5: local address bits 31..29 read zero
// R6: local address is external bus address
// R7: count bits 25..0, zero means 64MB
// R8: longword units only, count low bits ignored
// R9: count reads remaining bytes during transfer
// R10: count bits 31..26 read zero
// R11: software reprograms addresses and count each transfer
// R12: power-on and software reset clear everything; software reset leaves the port ack and read data as they were
// R13: registers reachable from both access ports
// R14: start bit launches, reads one while busy
// R15: termination flag sets always, write one clears
// R16: stop bit forces end and reads one
// R17: direction bit selects pci-to-local or reverse
// R18: each longword advances addresses, count minus four
`timescale 1ns/100ps
module pci_dma_address_count
   import dma_addr_count_pkg::*;
#(
   parameter int CHANNELS = NUM_CHAN
)
(
   // clock and resets
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic soft_rst_i,
   // internal peripheral bus register port
   input wire logic pp_req_i,
   input wire logic pp_we_i,
   input wire logic [ADDR_W-1:0] pp_addr_i,
   input wire logic [DATA_W-1:0] pp_wdata_i,
   output logic pp_ack_o,
   output logic [DATA_W-1:0] pp_rdata_o,
   // pci bus register port
   input wire logic pci_req_i,
   input wire logic pci_we_i,
   input wire logic [ADDR_W-1:0] pci_addr_i,
   input wire logic [DATA_W-1:0] pci_wdata_i,
   output logic pci_ack_o,
   output logic [DATA_W-1:0] pci_rdata_o,
   // longword mover
   output logic xfer_valid_o,
   output logic [CHAN_W-1:0] xfer_chan_o,
   output logic [DATA_W-1:0] xfer_pci_addr_o,
   output logic [LOCAL_W-1:0] xfer_local_addr_o,
   output logic [2:0] xfer_area_o,
   output logic xfer_dir_o,
   output logic xfer_io_space_o,
   output logic [1:0] xfer_align_o,
   input wire logic xfer_ready_i,
   input wire logic xfer_error_i,
   // channel status
   output logic [CHANNELS-1:0] busy_o,
   output logic [CHANNELS-1:0] term_irq_o
);

   // ==========================================================
   // channel state
   logic [DATA_W-1:0] pci_addr [CHANNELS];
   logic [LOCAL_W-1:0] local_addr [CHANNELS];
   logic [REMAIN_W-1:0] remain [CHANNELS];
   logic [CTRL_W-1:0] ctrl [CHANNELS];
   logic [DATA_W-1:0] next_pci_addr [CHANNELS];
   logic [LOCAL_W-1:0] next_local_addr [CHANNELS];
   logic [REMAIN_W-1:0] next_remain [CHANNELS];
   logic [CTRL_W-1:0] next_ctrl [CHANNELS];

   // mover output registers
   logic next_valid;
   logic [CHAN_W-1:0] next_chan;
   logic [DATA_W-1:0] next_out_pci;
   logic [LOCAL_W-1:0] next_out_local;
   logic next_dir;
   logic next_io_space;
   logic [1:0] next_align;

   // access ports
   logic pp_take;
   logic pci_take;
   logic [DATA_W-1:0] pp_rd_value;
   logic [DATA_W-1:0] pci_rd_value;
   logic wr_stb;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;

   // ==========================================================
   // read view of one register; reserved bits come back as zero
   function automatic logic [DATA_W-1:0] read_reg(input logic [SEL_W-1:0] sel,
      input logic [DATA_W-1:0] pa, input logic [LOCAL_W-1:0] la,
      input logic [REMAIN_W-1:0] rm, input logic [CTRL_W-1:0] ct);
      logic [DATA_W-1:0] v;
      v = RESET_WORD;
      if (sel == SEL_PCI_START)
      begin
         v = pa;
      end
      else if (sel == SEL_LOCAL_START)
      begin
         v = {3'h0, la}; // R5
      end
      else if (sel == SEL_BYTE_COUNT)
      begin
         v = {6'h00, rm[COUNT_W-1:0]}; // R9 R10
      end
      else
      begin
         v = {21'h00_0000, ct}; // R14
      end
      return v;
   endfunction

   // local address step; hold mode keeps the high part and wraps the low five bits
   function automatic logic [LOCAL_W-1:0] step_local(input logic [LOCAL_W-1:0] la,
      input logic hold);
      logic [LOCAL_W-1:0] inc;
      inc = la + ADDR_STEP[LOCAL_W-1:0];
      if (hold)
      begin
         inc = {la[LOCAL_W-1:HOLD_LO_BITS], inc[HOLD_LO_BITS-1:0]};
      end
      return inc;
   endfunction

   // ==========================================================
   // register ports; the peripheral bus wins a same-cycle collision, pci waits
   reg_access_port pp_port
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .req_i(pp_req_i),
      .rd_value_i(pp_rd_value),
      .grant_i(1'b1),
      .take_o(pp_take),
      .ack_o(pp_ack_o),
      .rdata_o(pp_rdata_o)
   );

   reg_access_port pci_port
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .req_i(pci_req_i),
      .rd_value_i(pci_rd_value),
      .grant_i(!pp_take),
      .take_o(pci_take),
      .ack_o(pci_ack_o),
      .rdata_o(pci_rdata_o)
   );

   // read values for both ports from the same channel registers
   assign pp_rd_value = read_reg(pp_addr_i[SEL_W-1:0], pci_addr[pp_addr_i[ADDR_W-1:SEL_W]],
      local_addr[pp_addr_i[ADDR_W-1:SEL_W]], remain[pp_addr_i[ADDR_W-1:SEL_W]],
      ctrl[pp_addr_i[ADDR_W-1:SEL_W]]); // R13
   assign pci_rd_value = read_reg(pci_addr_i[SEL_W-1:0], pci_addr[pci_addr_i[ADDR_W-1:SEL_W]],
      local_addr[pci_addr_i[ADDR_W-1:SEL_W]], remain[pci_addr_i[ADDR_W-1:SEL_W]],
      ctrl[pci_addr_i[ADDR_W-1:SEL_W]]); // R13

   // one write path serves both ports since only one is taken per cycle
   always_comb
   begin
      wr_stb = (pp_take && pp_we_i) || (pci_take && pci_we_i); // R13
      wr_addr = pp_take ? pp_addr_i : pci_addr_i;
      wr_data = pp_take ? pp_wdata_i : pci_wdata_i;
   end

   // ==========================================================
   // per-channel next state: mover beats first, then software writes
   always_comb
   begin
      logic beat;
      logic fault;
      logic ending;
      logic wr_here;
      logic [REMAIN_W-1:0] dec;
      logic [REMAIN_W-1:0] loaded;
      beat = 1'b0;
      fault = 1'b0;
      ending = 1'b0;
      wr_here = 1'b0;
      dec = '0;
      loaded = '0;
      for (int c = 0; c < CHANNELS; c++)
      begin
         next_pci_addr[c] = pci_addr[c];
         next_local_addr[c] = local_addr[c];
         next_remain[c] = remain[c];
         next_ctrl[c] = ctrl[c];
         beat = xfer_valid_o && xfer_ready_i && (xfer_chan_o == CHAN_W'(c))
            && ctrl[c][START_BIT];
         fault = xfer_valid_o && xfer_error_i && (xfer_chan_o == CHAN_W'(c))
            && ctrl[c][START_BIT];
         wr_here = wr_stb && (wr_addr[ADDR_W-1:SEL_W] == CHAN_W'(c));
         dec = remain[c] - LW_STEP;
         ending = 1'b0;
         // a moved longword steps both addresses and the count
         if (beat)
         begin
            next_pci_addr[c] = pci_addr[c] + ADDR_STEP; // R18
            next_local_addr[c] = step_local(local_addr[c],
               ctrl[c][LOCAL_ADDRESS_HOLD_BIT]); // R18 R6
            next_remain[c] = dec; // R18
            if (dec == '0)
            begin
               ending = 1'b1; // R18
               next_ctrl[c][END_STATUS_BIT] = 1'b0;
            end
         end
         // a mover error ends the channel abnormally
         if (fault)
         begin
            ending = 1'b1;
            next_ctrl[c][END_STATUS_BIT] = 1'b1;
         end
         // software writes; address and count writes mid-transfer are honoured as written
         if (wr_here)
         begin
            if (wr_addr[SEL_W-1:0] == SEL_PCI_START)
            begin
               next_pci_addr[c] = wr_data; // R2
            end
            else if (wr_addr[SEL_W-1:0] == SEL_LOCAL_START)
            begin
               next_local_addr[c] = wr_data[LOCAL_W-1:0]; // R3 R5
            end
            else if (wr_addr[SEL_W-1:0] == SEL_BYTE_COUNT)
            begin
               next_remain[c] = {1'b0, wr_data[COUNT_W-1:0]}; // R7 R10
            end
            else
            begin
               // mode bits; bit 4 and the status bits are not writable
               next_ctrl[c][DIR_BIT] = wr_data[DIR_BIT]; // R17
               next_ctrl[c][PCI_SPACE_SELECT_BIT] = wr_data[PCI_SPACE_SELECT_BIT];
               next_ctrl[c][LOCAL_ADDRESS_HOLD_BIT] = wr_data[LOCAL_ADDRESS_HOLD_BIT];
               next_ctrl[c][TERM_IRQ_ENABLE_BIT] = wr_data[TERM_IRQ_ENABLE_BIT];
               next_ctrl[c][ALIGN_HI_BIT:ALIGN_LO_BIT] = wr_data[ALIGN_HI_BIT:ALIGN_LO_BIT];
               if (wr_data[TERM_STATUS_BIT])
               begin
                  next_ctrl[c][TERM_STATUS_BIT] = 1'b0; // R15
               end
               // forced stop only means something while the channel runs
               if (wr_data[FORCE_STOP_BIT] && ctrl[c][START_BIT] && !ending)
               begin
                  ending = 1'b1; // R16
                  next_ctrl[c][FORCE_STOP_BIT] = 1'b1; // R16
                  next_ctrl[c][END_STATUS_BIT] = 1'b1;
               end
               // launch from idle; a start while busy or with stop is ignored
               else if (wr_data[START_BIT] && !wr_data[FORCE_STOP_BIT]
                  && !ctrl[c][START_BIT])
               begin
                  loaded = {1'b0, remain[c][COUNT_W-1:LW_LO_BITS], 2'b00}; // R8
                  if (loaded == '0)
                  begin
                     loaded = REMAIN_MAX; // R7
                  end
                  next_remain[c] = loaded;
                  next_ctrl[c][START_BIT] = 1'b1; // R14
                  next_ctrl[c][FORCE_STOP_BIT] = 1'b0;
                  next_ctrl[c][END_STATUS_BIT] = 1'b0;
               end
            end
         end
         // ending sets the flag after any clear, so the event is never lost
         if (ending)
         begin
            next_ctrl[c][START_BIT] = 1'b0; // R14
            next_ctrl[c][TERM_STATUS_BIT] = 1'b1; // R15
         end
         next_ctrl[c][4] = 1'b0;
         // software reset overrides everything in this cycle
         if (soft_rst_i)
         begin
            next_pci_addr[c] = RESET_WORD; // R12
            next_local_addr[c] = RESET_WORD[LOCAL_W-1:0]; // R12
            next_remain[c] = RESET_WORD[REMAIN_W-1:0]; // R12
            next_ctrl[c] = RESET_WORD[CTRL_W-1:0]; // R12
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            pci_addr[c] <= RESET_WORD; // R12
            local_addr[c] <= RESET_WORD[LOCAL_W-1:0];
            remain[c] <= RESET_WORD[REMAIN_W-1:0];
            ctrl[c] <= RESET_WORD[CTRL_W-1:0];
         end
      end
      else
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            pci_addr[c] <= next_pci_addr[c];
            local_addr[c] <= next_local_addr[c];
            remain[c] <= next_remain[c];
            ctrl[c] <= next_ctrl[c];
         end
      end
   end

   // ==========================================================
   // mover offer: lowest busy channel, built from next state so it is never stale;
   // fixed priority only, the arbitration mode register lives elsewhere
   always_comb
   begin
      next_valid = 1'b0;
      next_chan = '0;
      for (int c = CHANNELS - 1; c >= 0; c--)
      begin
         if (next_ctrl[c][START_BIT])
         begin
            next_valid = 1'b1;
            next_chan = CHAN_W'(c); // R1
         end
      end
      next_out_pci = {next_pci_addr[next_chan][DATA_W-1:LW_LO_BITS], 2'b00}; // R2
      next_out_local = {next_local_addr[next_chan][LOCAL_W-1:LW_LO_BITS], 2'b00}; // R3
      next_dir = next_ctrl[next_chan][DIR_BIT]; // R17
      next_io_space = next_ctrl[next_chan][PCI_SPACE_SELECT_BIT];
      next_align = next_ctrl[next_chan][ALIGN_HI_BIT:ALIGN_LO_BIT];
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         xfer_valid_o <= 1'b0;
         xfer_chan_o <= '0;
         xfer_pci_addr_o <= RESET_WORD;
         xfer_local_addr_o <= RESET_WORD[LOCAL_W-1:0];
         xfer_dir_o <= 1'b0;
         xfer_io_space_o <= 1'b0;
         xfer_align_o <= 2'b00;
      end
      else
      begin
         xfer_valid_o <= next_valid;
         xfer_chan_o <= next_chan;
         xfer_pci_addr_o <= next_out_pci;
         xfer_local_addr_o <= next_out_local;
         xfer_dir_o <= next_dir;
         xfer_io_space_o <= next_io_space;
         xfer_align_o <= next_align;
      end
   end

   // area select rides on the registered local address
   assign xfer_area_o = xfer_local_addr_o[AREA_HI_BIT:AREA_LO_BIT]; // R4

   // status levels straight from control flops
   always_comb
   begin
      for (int c = 0; c < CHANNELS; c++)
      begin
         busy_o[c] = ctrl[c][START_BIT];
         term_irq_o[c] = ctrl[c][TERM_STATUS_BIT] && ctrl[c][TERM_IRQ_ENABLE_BIT];
      end
   end

endmodule // pci_dma_address_count

/* tb/pci_dma_address_count_sva.sv */
// Purpose: port-level checks for the dma address/count block
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the block from the bench top file
`timescale 1ns/100ps
module pci_dma_address_count_sva
   import dma_addr_count_pkg::*;
#(
   parameter int CHANNELS = NUM_CHAN
)
(
   // clock and resets
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic soft_rst_i,
   // register ports
   input wire logic pp_req_i,
   input wire logic pp_we_i,
   input wire logic [ADDR_W-1:0] pp_addr_i,
   input wire logic [DATA_W-1:0] pp_wdata_i,
   input wire logic pp_ack_o,
   input wire logic pci_req_i,
   input wire logic pci_ack_o,
   // mover and status
   input wire logic xfer_valid_o,
   input wire logic [CHAN_W-1:0] xfer_chan_o,
   input wire logic [DATA_W-1:0] xfer_pci_addr_o,
   input wire logic [LOCAL_W-1:0] xfer_local_addr_o,
   input wire logic [2:0] xfer_area_o,
   input wire logic xfer_ready_i,
   input wire logic xfer_error_i,
   input wire logic [CHANNELS-1:0] busy_o,
   input wire logic [CHANNELS-1:0] term_irq_o
);
   // ==========
   // helpers
   logic [CHAN_W-1:0] take_chan;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // channel on pp_addr_i at the previous edge, so the start check knows where to look
   always_ff @(posedge clk_i)
      take_chan <= pp_addr_i[ADDR_W-1:SEL_W];
   sequence s_beat;
      xfer_valid_o && xfer_ready_i && !xfer_error_i;
   endsequence
   sequence s_cleared;
      busy_o == '0 && term_irq_o == '0 ##1 !xfer_valid_o;
   endsequence
   // ==========
   // checks
   property p_pp_ack;
      pp_req_i && !pp_ack_o |=> pp_ack_o ##1 !pp_ack_o;
   endproperty
   a_pp_ack: assert property (p_pp_ack) else $error("pp ack missing");
   property p_pci_ack;
      pci_req_i && !pci_ack_o && !(pp_req_i && !pp_ack_o) |=> pci_ack_o;
   endproperty
   a_pci_ack: assert property (p_pci_ack) else $error("pci ack missing");
   property p_pci_lsb;
      xfer_valid_o |-> xfer_pci_addr_o[1:0] == 2'h0;
   endproperty
   a_pci_lsb: assert property (p_pci_lsb) else $error("pci addr unaligned");
   property p_loc_lsb;
      xfer_valid_o |-> xfer_local_addr_o[1:0] == 2'h0;
   endproperty
   a_loc_lsb: assert property (p_loc_lsb) else $error("local addr unaligned");
   property p_area;
      s_beat ##1 (xfer_valid_o && $stable(xfer_chan_o) && !$past(soft_rst_i))
         |-> $stable(xfer_area_o) || xfer_local_addr_o[AREA_LO_BIT-1:0] == '0;
   endproperty
   a_area: assert property (p_area) else $error("area select wrong");
   // next longword of the same channel sits four bytes further on in pci space
   property p_step;
      s_beat ##1 (xfer_valid_o && $stable(xfer_chan_o) && !$past(soft_rst_i))
         |-> xfer_pci_addr_o == $past(xfer_pci_addr_o) + ADDR_STEP;
   endproperty
   a_step: assert property (p_step) else $error("address step wrong");
   property p_hold;
      xfer_valid_o && busy_o[xfer_chan_o] && !xfer_ready_i && !xfer_error_i && !pp_req_i
         && !pci_req_i && !soft_rst_i |=> xfer_valid_o && $stable(xfer_pci_addr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("offer moved unanswered");
   property p_soft;
      soft_rst_i |=> s_cleared;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset left state");
   property p_start;
      pp_req_i && !pp_ack_o && pp_we_i && pp_addr_i[SEL_W-1:0] == SEL_CONTROL && !soft_rst_i
         && pp_wdata_i[START_BIT] && !pp_wdata_i[FORCE_STOP_BIT] |=> busy_o[take_chan];
   endproperty
   a_start: assert property (p_start) else $error("start did not launch");
endmodule // pci_dma_address_count_sva

/* tb/longword_mover_model.sv */
// Purpose: behavioural longword mover facing the dma block
// Assumes: the offer stands until it is answered
// Notes: stall 7 leaves the offer unanswered; errors only on bench command
`timescale 1ns/100ps
module longword_mover_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // offer and bench commands
   input wire logic valid_i,
   input wire logic [2:0] stall_i,
   input wire logic err_req_i,
   // answer
   output logic ready_o,
   output logic error_o
);
   logic [2:0] wait_cnt;
   logic [2:0] next_wait_cnt;
   // ==========
   // one longword taken once the offer has waited stall_i cycles
   assign ready_o = valid_i && stall_i != 3'h7 && wait_cnt >= stall_i && !err_req_i;
   assign error_o = valid_i && err_req_i;
   // restart after every ready answer so each beat pays the full stall
   always_comb
   begin
      next_wait_cnt = wait_cnt;
      if (!valid_i || ready_o)
         next_wait_cnt = 3'h0;
      else if (wait_cnt != 3'h7)
         next_wait_cnt = wait_cnt + 3'h1;
   end
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wait_cnt <= 3'h0;
      else
         wait_cnt <= next_wait_cnt;
   end
endmodule // longword_mover_model

/* tb/pci_dma_address_count_tb.sv */
// Purpose: self-checking bench for the dma address/count block
// Assumes: inputs change on the falling edge, one register access at a time
// Notes: reads and beats are noted in queues and matched as they appear
`timescale 1ns/100ps
module pci_dma_address_count_tb;
   import dma_addr_count_pkg::*;
   logic clk_i, rst_n_i, soft_rst_i, pp_req_i, pp_we_i, pci_req_i, pci_we_i, err_req, dir;
   logic pp_ack_o, pci_ack_o, xfer_valid_o, xfer_dir_o, xfer_io_space_o, xfer_ready_i, xfer_error_i;
   logic [ADDR_W-1:0] pp_addr_i, pci_addr_i;
   logic [DATA_W-1:0] pp_wdata_i, pci_wdata_i, pp_rdata_o, pci_rdata_o, xfer_pci_addr_o, pa, la;
   logic [CHAN_W-1:0] xfer_chan_o;
   logic [LOCAL_W-1:0] xfer_local_addr_o;
   logic [2:0] xfer_area_o, stall;
   logic [1:0] xfer_align_o;
   logic [NUM_CHAN-1:0] busy_o, term_irq_o;
   logic [32:0] rq[$], note;
   logic [69:0] bq[$];
   logic [31:0] msk[4] = '{32'hffff_ffff, 32'h1fff_ffff, 32'h03ff_ffff, 32'h0000_06ac}, d, m;
   int err_count, checked, seed, n;
   pci_dma_address_count #(.CHANNELS(NUM_CHAN)) dut (.clk_i, .rst_n_i, .soft_rst_i, .pp_req_i,
      .pp_we_i, .pp_addr_i, .pp_wdata_i, .pp_ack_o, .pp_rdata_o, .pci_req_i, .pci_we_i,
      .pci_addr_i, .pci_wdata_i, .pci_ack_o, .pci_rdata_o, .xfer_valid_o, .xfer_chan_o,
      .xfer_pci_addr_o, .xfer_local_addr_o, .xfer_area_o, .xfer_dir_o, .xfer_io_space_o,
      .xfer_align_o, .xfer_ready_i, .xfer_error_i, .busy_o, .term_irq_o);
   longword_mover_model mover (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(xfer_valid_o),
      .stall_i(stall), .err_req_i(err_req), .ready_o(xfer_ready_i), .error_o(xfer_error_i));
   // ==========
   // clock
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // ==========
   // compare and access tasks
   task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_beat(input logic [69:0] e, input logic [69:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   // request held until the edge that shows ack, released on the next falling edge
   task automatic acc(input logic pci, input logic we, input logic [3:0] a,
      input logic [31:0] wd, input logic [31:0] ex);
      int t = 0;
      @(negedge clk_i);
      {pp_req_i, pci_req_i, pp_we_i, pci_we_i} = {!pci, pci, we, we};
      {pp_addr_i, pci_addr_i, pp_wdata_i, pci_wdata_i} = {a, a, wd, wd};
      rq.push_back({!we, ex});
      do
      begin
         @(posedge clk_i);
         t++;
      end
      while ((pci ? pci_ack_o : pp_ack_o) !== 1'b1 && t < 20);
      cmp_word(32'h0, 32'(t >= 20));
      @(negedge clk_i);
      {pp_req_i, pci_req_i} = 2'h0;
   endtask
   task automatic prog(input logic [1:0] c, input logic [31:0] p, l, cnt);
      for (int s = 0; s < 3; s++)
         acc(1'b1, 1'b1, {c, 2'(s)}, s == 0 ? p : (s == 1 ? l : cnt), '0);
   endtask
   task automatic wait_idle(input int c);
      int t = 0;
      while (busy_o[c] !== 1'b0 && t < 400)
      begin
         @(negedge clk_i);
         t++;
      end
      cmp_word(32'h0, {31'h0, busy_o[c]});
   endtask
   task automatic chk_clear();
      for (int i = 0; i < 16; i++)
         acc(i[0], 1'b0, i[3:0], '0, '0);
   endtask
   task automatic test_done();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ==========
   // monitor: each result takes the oldest note of its kind
   always @(posedge clk_i)
   begin
      if (pp_ack_o === 1'b1 || pci_ack_o === 1'b1)
      begin
         note = rq.pop_front();
         if (note[32])
            cmp_word(note[31:0], pp_ack_o ? pp_rdata_o : pci_rdata_o);
      end
      if (xfer_valid_o === 1'b1 && xfer_ready_i === 1'b1)
         cmp_beat(bq.pop_front(), {xfer_chan_o, xfer_dir_o, xfer_io_space_o, xfer_align_o,
            xfer_area_o, xfer_pci_addr_o, xfer_local_addr_o});
   end
   // watchdog: the tests need well under 5000 cycles
   initial
   begin
      #(20 * 5000);
      err_count++;
      test_done();
   end
   // ==========
   // main sequence
   initial
   begin
      {seed, err_count, checked} = {32'h6107, 32'h0, 32'h0};
      {rst_n_i, soft_rst_i, pp_req_i, pp_we_i, pci_req_i, pci_we_i, err_req} = '0;
      {pp_addr_i, pci_addr_i, pp_wdata_i, pci_wdata_i} = '0;
      stall = 3'h7;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      chk_clear();
      $display("test reset values done");
      // random words in through one port, back out through the other
      for (int i = 0; i < 16; i++)
      begin
         d = $random(seed) & msk[i[1:0]];
         acc(1'b0, 1'b1, i[3:0], d, '0);
         acc(1'b1, 1'b0, i[3:0], '0, d);
      end
      $display("test register fields done");
      // offer held while channels 0 and 1 read their count, then beats at a stall of c cycles
      for (int c = 0; c < 4; c++)
      begin
         {n, dir, m} = {2 + c, c[0], 21'h0, c[1:0], 4'h4, 1'b0, c[1], c[0], 2'h0};
         pa = $random(seed) & 32'hfff0_0fff;
         la = $random(seed) & 32'h1ff0_0fff;
         prog(c[1:0], pa, la, 32'(n * 4 + (c > 1 ? 3 : 0)));
         for (int k = 0; k < n; k++)
            bq.push_back({c[1:0], dir, c[1], c[1:0], la[28:26], (pa & ~32'h3) + 32'(4 * k),
               29'((la & ~32'h3) + 32'(4 * k))});
         acc(1'b0, 1'b1, {c[1:0], SEL_CONTROL}, m | 32'h1, '0);
         if (c < 2)
            acc(1'b1, 1'b0, {c[1:0], SEL_BYTE_COUNT}, '0, 32'(n * 4));
         @(negedge clk_i);
         stall = 3'(c);
         wait_idle(c);
         cmp_word(32'h1, {31'h0, term_irq_o[c]});
         acc(1'b1, 1'b0, {c[1:0], SEL_CONTROL}, '0, m | 32'h40);
         acc(1'b1, 1'b1, {c[1:0], SEL_CONTROL}, m | 32'h40, '0);
         acc(1'b0, 1'b0, {c[1:0], SEL_CONTROL}, '0, m);
         stall = 3'h7;
      end
      $display("test transfers done");
      // zero count runs long; stop it while the offer is held
      prog(2'h1, pa, la, '0);
      acc(1'b0, 1'b1, {2'h1, SEL_CONTROL}, 32'h81, '0);
      cmp_word(32'h2, {28'h0, busy_o});
      acc(1'b1, 1'b0, {2'h1, SEL_BYTE_COUNT}, '0, '0);
      acc(1'b0, 1'b1, {2'h1, SEL_CONTROL}, 32'h82, '0);
      wait_idle(1);
      acc(1'b1, 1'b0, {2'h1, SEL_CONTROL}, '0, 32'h1c2);
      // abnormal end from the mover
      prog(2'h2, pa, la, 32'h8);
      acc(1'b0, 1'b1, {2'h2, SEL_CONTROL}, 32'h81, '0);
      err_req = 1'b1;
      wait_idle(2);
      err_req = 1'b0;
      acc(1'b1, 1'b0, {2'h2, SEL_CONTROL}, '0, 32'h1c0);
      $display("test stop and error done");
      // software reset in mid transfer
      prog(2'h3, pa, la, 32'h8);
      acc(1'b0, 1'b1, {2'h3, SEL_CONTROL}, 32'h81, '0);
      soft_rst_i = 1'b1;
      @(negedge clk_i);
      soft_rst_i = 1'b0;
      cmp_word(32'h0, {28'h0, busy_o});
      chk_clear();
      $display("test software reset done");
      test_done();
   end
endmodule // pci_dma_address_count_tb
bind pci_dma_address_count pci_dma_address_count_sva #(.CHANNELS(CHANNELS)) u_sva (.clk_i,
   .rst_n_i, .soft_rst_i, .pp_req_i, .pp_we_i, .pp_addr_i, .pp_wdata_i, .pp_ack_o, .pci_req_i,
   .pci_ack_o, .xfer_valid_o, .xfer_chan_o, .xfer_pci_addr_o, .xfer_local_addr_o, .xfer_area_o,
   .xfer_ready_i, .xfer_error_i, .busy_o, .term_irq_o);
